// ==== design/rtcal_pkg.sv ====
// Purpose: constants for the alarm and serial register block
// Assumes: 4-bit register addresses, 8-bit data, MSB-first serial link
// Notes:   control and flag bit positions follow the register map
package rtcal_pkg;
    localparam logic [3:0] ADDR_MIN       = 4'h1;
    localparam logic [3:0] ADDR_HOUR      = 4'h2;
    localparam logic [3:0] ADDR_WEEK      = 4'h3;
    localparam logic [3:0] ADDR_DAY       = 4'h4;
    localparam logic [3:0] ADDR_MIN_ALM   = 4'h8;
    localparam logic [3:0] ADDR_HOUR_ALM  = 4'h9;
    localparam logic [3:0] ADDR_WD_ALM    = 4'hA;
    localparam logic [3:0] ADDR_EXT       = 4'hD;
    localparam logic [3:0] ADDR_FLAG      = 4'hE;
    localparam logic [3:0] ADDR_CTRL      = 4'hF;
    localparam logic [3:0] MODE_READ      = 4'h9;
    localparam logic [3:0] MODE_WRITE     = 4'h1;
    localparam int         EXCL_BIT       = 7;
    localparam int         RAM_BIT        = 6;
    localparam int         DWSEL_BIT      = 6;
    localparam int         AFLAG_BIT      = 3;
    localparam int         AIRQ_BIT       = 3;
    localparam int         RESET_BIT      = 0;
    localparam logic [7:0] MIN_MASK       = 8'h7F;
    localparam logic [7:0] HOUR_MASK      = 8'h3F;
    localparam logic [7:0] WEEK_MASK      = 8'h7F;
    localparam logic [7:0] DAY_MASK       = 8'h3F;
    localparam logic [7:0] FLAG_MASK      = 8'h08;
    localparam logic [7:0] CTRL_MASK      = 8'h09;
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam logic [2:0] BIT_LAST       = 3'h7;
endpackage

// ==== design/rtcal_regfile.sv ====
// Purpose: sixteen-entry byte register store for the serial port
// Assumes: one write port, one read port, same clock
// Notes:   read data comes out of a register, one cycle after the address
`timescale 1ns/100ps
module rtcal_regfile (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       srst,
    // write port
    input  wire logic       wr_en,
    input  wire logic [3:0] wr_addr,
    input  wire logic [7:0] wr_data,
    // read port
    input  wire logic [3:0] rd_addr,
    output logic      [7:0] rd_data
);
    typedef struct packed {
        logic [15:0][7:0] mem;
        logic [7:0]       rd;
    } rtcal_rf_t;

    rtcal_rf_t st;
    rtcal_rf_t next_st;

    always_comb begin
        next_st = st;
        if (wr_en) begin
            next_st.mem[wr_addr] = wr_data;
        end
        next_st.rd = st.mem[rd_addr];
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data = st.rd;
endmodule

// ==== design/rtcal_top.sv ====
// Purpose: alarm compare, alarm flag and interrupt, serial register port
// Assumes: time counters outside supply BCD minute, hour, date and a bit-per-day weekday
// Notes:   serial pins sampled through two flops; link clock is slow
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////
// What this block does
// - alarm minute, hour, day registers at 8-A
// - register A is weekday mask or date
// - weekday mode: any set day bit matches
// - full match of enabled targets sets alarm flag
// - match with irq enable drives interrupt low
// - exclude bit removes register from comparison
// - all excluded: alarm fires every minute
// - hour and date bit 6 plain storage
// - alarm flag sticks until written zero
// - writing one to alarm flag does nothing
// - clearing alarm flag releases interrupt pin
// - clearing irq enable releases and blocks interrupt
// - interrupt low persists until flag or enable cleared
// - interrupt pin shared with other sources
// - chip select frames address then whole bytes
// - all serial bits most significant first
// - address increments per byte, F wraps to 0
// - incomplete write byte at deselect is dropped
// - mode 9 reads, mode 1 writes
// - other mode ignores data, output stays off
// - select 0 weekday, 1 date
// - reset bit set blocks alarm events
// - match only on counters advancing into target
module rtcal_top (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       srst,
    // current time from the counters
    input  wire logic [6:0] cur_min,
    input  wire logic [5:0] cur_hour,
    input  wire logic [6:0] cur_weekday,
    input  wire logic [5:0] cur_date,
    // other interrupt sources sharing the pin
    input  wire logic       other_irq,
    // serial link pins
    input  wire logic       chip_select,
    input  wire logic       serial_clk,
    input  wire logic       serial_in,
    output logic            serial_out,
    output logic            serial_out_oe,
    // interrupt pin, open drain
    output logic            irq_out_n,
    output logic            irq_out_oe
);
    typedef enum logic [3:0] {
        RTCAL_IDLE  = 4'b0001,
        RTCAL_CMD   = 4'b0010,
        RTCAL_DATA  = 4'b0100,
        RTCAL_SKIP  = 4'b1000
    } rtcal_state_t;

    typedef struct packed {
        logic [1:0]   cs_sync;
        logic [1:0]   sck_sync;
        logic [1:0]   sdi_sync;
        logic         sck_prev;
        rtcal_state_t state;
        logic [2:0]   bit_cnt;
        logic [7:0]   shift;
        logic [3:0]   addr;
        logic         is_read;
        logic         load_pend;
        logic [7:0]   tx;
        logic [7:0]   alm_min;
        logic [7:0]   alm_hour;
        logic [7:0]   alm_wd;
        logic         day_week_select;
        logic         alarm_flag;
        logic         alarm_irq_enable;
        logic         rtc_reset;
        logic         match_prev;
        logic [6:0]   last_min;
        logic         sdo;
        logic         sdo_oe;
        logic         irq_oe;
    } rtcal_st_t;

    rtcal_st_t st;
    rtcal_st_t next_st;

    logic       rf_wr;
    logic [3:0] rf_waddr;
    logic [7:0] rf_wdata;
    logic [7:0] rf_rdata;
    logic       cs;
    logic       sck_rise;
    logic       sck_fall;
    logic       sdi;
    logic       day_ok;
    logic       match_now;
    logic       alarm_event;
    logic [7:0] rd_byte;
    logic       wr_done;
    logic [7:0] wr_byte;

    rtcal_regfile u_regfile (
        .core_clk (core_clk),
        .srst     (srst),
        .wr_en    (rf_wr),
        .wr_addr  (rf_waddr),
        .wr_data  (rf_wdata),
        .rd_addr  (next_st.addr),
        .rd_data  (rf_rdata)
    );

    ////////////////////////////////////////////////////////////////////
    // synchronised pins; only the second stage is read
    assign cs       = st.cs_sync[1];
    assign sdi      = st.sdi_sync[1];
    assign sck_rise = st.sck_sync[1] & ~st.sck_prev;
    assign sck_fall = ~st.sck_sync[1] & st.sck_prev;

    ////////////////////////////////////////////////////////////////////
    // alarm compare
    always_comb begin
        if (st.day_week_select) begin
            day_ok = (st.alm_wd & rtcal_pkg::DAY_MASK)
                     == {2'h0, cur_date};
        end else begin
            day_ok = |(st.alm_wd[6:0] & cur_weekday);
        end
        // bit 6 of hour and date is masked out of the compare
        match_now =
            (st.alm_min[rtcal_pkg::EXCL_BIT] ||
             (st.alm_min & rtcal_pkg::MIN_MASK) == {1'b0, cur_min}) &&
            (st.alm_hour[rtcal_pkg::EXCL_BIT] ||
             (st.alm_hour & rtcal_pkg::HOUR_MASK) == {2'h0, cur_hour}) &&
            (st.alm_wd[rtcal_pkg::EXCL_BIT] || day_ok);
    end

    // all excluded: match stays high, so pulse on each minute change
    logic min_tick;
    logic all_excl;
    assign all_excl = st.alm_min[rtcal_pkg::EXCL_BIT] &
                      st.alm_hour[rtcal_pkg::EXCL_BIT] &
                      st.alm_wd[rtcal_pkg::EXCL_BIT];

    ////////////////////////////////////////////////////////////////////
    // register image for reads; spare flag and control bits read zero, other spare bits read back the stored byte
    always_comb begin
        unique case (st.addr)
            rtcal_pkg::ADDR_MIN_ALM:  rd_byte = st.alm_min;
            rtcal_pkg::ADDR_HOUR_ALM: rd_byte = st.alm_hour;
            rtcal_pkg::ADDR_WD_ALM:   rd_byte = st.alm_wd;
            rtcal_pkg::ADDR_EXT:
                rd_byte = rf_rdata & ~(8'h01 << rtcal_pkg::DWSEL_BIT)
                          | ({7'h00, st.day_week_select}
                             << rtcal_pkg::DWSEL_BIT);
            rtcal_pkg::ADDR_FLAG:
                rd_byte = {7'h00, st.alarm_flag} << rtcal_pkg::AFLAG_BIT;
            rtcal_pkg::ADDR_CTRL:
                rd_byte = ({7'h00, st.alarm_irq_enable}
                           << rtcal_pkg::AIRQ_BIT) |
                          {7'h00, st.rtc_reset};
            default:                  rd_byte = rf_rdata;
        endcase
    end

    assign wr_byte = {st.shift[6:0], sdi};
    assign wr_done = st.state == RTCAL_DATA && !st.is_read && sck_rise &&
                     st.bit_cnt == rtcal_pkg::BIT_LAST && cs;
    assign rf_wr    = wr_done;
    assign rf_waddr = st.addr;
    assign rf_wdata = wr_byte;

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_st = st;
        next_st.cs_sync  = {st.cs_sync[0], chip_select};
        next_st.sck_sync = {st.sck_sync[0], serial_clk};
        next_st.sdi_sync = {st.sdi_sync[0], serial_in};
        next_st.sck_prev = st.sck_sync[1];

        // serial port
        if (!cs) begin
            next_st.state   = RTCAL_IDLE;
            next_st.sdo_oe  = 1'b0;
            next_st.bit_cnt = 3'h0;
        end else begin
            unique case (st.state)
                RTCAL_IDLE: begin
                    next_st.state   = RTCAL_CMD;
                    next_st.bit_cnt = 3'h0;
                end
                RTCAL_CMD: begin
                    if (sck_rise) begin
                        next_st.shift   = wr_byte;
                        next_st.bit_cnt = st.bit_cnt + 3'h1;
                        if (st.bit_cnt == rtcal_pkg::BIT_LAST) begin
                            next_st.addr = wr_byte[7:4];
                            if (wr_byte[3:0] == rtcal_pkg::MODE_READ) begin
                                next_st.state     = RTCAL_DATA;
                                next_st.is_read   = 1'b1;
                                next_st.load_pend = 1'b1;
                            end else if (wr_byte[3:0] ==
                                         rtcal_pkg::MODE_WRITE) begin
                                next_st.state   = RTCAL_DATA;
                                next_st.is_read = 1'b0;
                            end else begin
                                next_st.state = RTCAL_SKIP;
                            end
                        end
                    end
                end
                RTCAL_DATA: begin
                    if (st.is_read && st.load_pend) begin
                        // regfile read is one cycle late; wait a cycle
                        next_st.load_pend = 1'b0;
                        next_st.tx        = rd_byte;
                    end
                    if (st.is_read && sck_fall) begin
                        next_st.sdo_oe = 1'b1;
                        next_st.sdo    = next_st.tx[7];
                        next_st.tx     = {next_st.tx[6:0], 1'b0};
                    end
                    if (sck_rise) begin
                        next_st.shift   = wr_byte;
                        next_st.bit_cnt = st.bit_cnt + 3'h1;
                        if (st.bit_cnt == rtcal_pkg::BIT_LAST) begin
                            next_st.addr = st.addr + 4'h1;
                            next_st.load_pend = st.is_read;
                        end
                    end
                end
                RTCAL_SKIP: begin
                    next_st.sdo_oe = 1'b0;
                end
                default: next_st.state = RTCAL_IDLE;
            endcase
        end

        // register writes from the link
        if (wr_done) begin
            unique case (st.addr)
                rtcal_pkg::ADDR_MIN_ALM:  next_st.alm_min  = wr_byte;
                rtcal_pkg::ADDR_HOUR_ALM: next_st.alm_hour = wr_byte;
                rtcal_pkg::ADDR_WD_ALM:   next_st.alm_wd   = wr_byte;
                rtcal_pkg::ADDR_EXT:
                    next_st.day_week_select = wr_byte[rtcal_pkg::DWSEL_BIT];
                rtcal_pkg::ADDR_FLAG:
                    if (!wr_byte[rtcal_pkg::AFLAG_BIT]) begin
                        next_st.alarm_flag = 1'b0;
                    end
                rtcal_pkg::ADDR_CTRL: begin
                    next_st.alarm_irq_enable =
                        wr_byte[rtcal_pkg::AIRQ_BIT];
                    next_st.rtc_reset = wr_byte[rtcal_pkg::RESET_BIT];
                end
                default: ;
            endcase
        end

        // alarm event: rising match, or each minute when all excluded
        next_st.match_prev = match_now;
        next_st.last_min   = cur_min;
        if (alarm_event) begin
            next_st.alarm_flag = 1'b1;
        end
        // pin low while flag and enable both set; no self clear
        next_st.irq_oe = (next_st.alarm_flag && next_st.alarm_irq_enable)
                         || other_irq;
    end

    // event: match rising on a minute step, or any step when all excluded
    assign min_tick = st.last_min != cur_min;
    always_comb begin
        if (st.rtc_reset) begin
            alarm_event = 1'b0;
        end else if (all_excl) begin
            alarm_event = min_tick;
        end else begin
            // a target already met when written fires only once the counters step away and back into it
            alarm_event = match_now && !st.match_prev && min_tick;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st                  <= '0;
            st.state            <= RTCAL_IDLE;
            st.alm_min          <= rtcal_pkg::REG_RESET;
            st.alm_hour         <= rtcal_pkg::REG_RESET;
            st.alm_wd           <= rtcal_pkg::REG_RESET;
            st.match_prev       <= 1'b1;
            st.last_min         <= cur_min;
        end else begin
            st <= next_st;
        end
    end

    assign serial_out    = st.sdo;
    assign serial_out_oe = st.sdo_oe;
    assign irq_out_n     = 1'b0;
    assign irq_out_oe    = st.irq_oe;
endmodule

// ==== dv/rtcal_host.sv ====
// Purpose: behavioural host on the serial register link
// Assumes: 125 ns link clock, clock idles low between frames
// Notes:   read bits sampled at the rising link edge
`timescale 1ns/100ps
module rtcal_host (
    // serial pins
    output logic      chip_select,
    output logic      serial_clk,
    output logic      serial_in,
    input  wire logic serial_out,
    input  wire logic serial_out_oe
);
    logic [63:0] rv;
    logic        saw_oe;
    event        got;
    initial begin
        chip_select = 1'b0;
        serial_clk  = 1'b0;
        serial_in   = 1'b0;
    end
    // odd offsets keep link edges off core edges
    task automatic xfer(input logic [63:0] w, input int n);
        rv = '0;
        saw_oe = 1'b0;
        // deselect gap of several core cycles so the sync sees it low
        #31.3 chip_select = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            #31.2 serial_in = w[i];
            #31.3 rv = {rv[62:0], serial_out_oe ? serial_out : 1'bx};
            saw_oe = saw_oe | serial_out_oe;
            serial_clk = 1'b1;
            #62.5 serial_clk = 1'b0;
        end
        // callers keep n whole bytes unless a drop is wanted
        #62.5 chip_select = 1'b0;
        serial_in = ~serial_in;
        -> got;
    endtask
endmodule

// ==== dv/rtcal_top_properties.sv ====
// Purpose: port checks for the alarm and serial block
// Assumes: link clock far slower than core_clk
// Notes:   history windows absorb the pin sync latency
`timescale 1ns/100ps
module rtcal_top_properties (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       srst,
    // stimulus side
    input wire logic [6:0] cur_min,
    input wire logic       other_irq,
    input wire logic       chip_select,
    input wire logic       serial_clk,
    // design outputs
    input wire logic       serial_out,
    input wire logic       serial_out_oe,
    input wire logic       irq_out_n,
    input wire logic       irq_out_oe
);
    logic [6:0] prev_min;
    logic [3:0] min_hist;
    logic [3:0] oth_hist;
    logic [3:0] cs_hist;
    always_ff @(posedge core_clk) begin
        prev_min <= cur_min;
        min_hist <= {min_hist[2:0], cur_min != prev_min};
        oth_hist <= {oth_hist[2:0], other_irq};
        cs_hist  <= {cs_hist[2:0], chip_select};
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////
    reset_quiet_a: assert property (disable iff (1'b0)
        srst |=> !serial_out_oe && !irq_out_oe) else $error("active in reset");
    shared_irq_a: assert property (
        other_irq |-> ##[1:3] irq_out_oe) else $error("shared irq lost");
    irq_cause_a: assert property ($rose(irq_out_oe) |->
        min_hist != 0 || oth_hist != 0 || cs_hist != 0)
        else $error("irq no cause");
    irq_release_a: assert property ($fell(irq_out_oe) |->
        oth_hist != 0 || cs_hist != 0) else $error("irq self cleared");
    drain_const_a: assert property (irq_out_n == 1'b0)
        else $error("irq pin value not low");
    out_frame_a: assert property (
        $rose(serial_out_oe) |-> cs_hist == 4'hF)
        else $error("drive outside frame");
    out_release_a: assert property (
        !chip_select [*6] |-> !serial_out_oe) else $error("data not released");
    out_hold_a: assert property (
        (chip_select && serial_clk) [*6] |=> $stable(serial_out))
        else $error("data moved while clock high");
    cover property ($rose(irq_out_oe) && oth_hist == 0);
    cover property ($rose(serial_out_oe));
    cover property ($fell(irq_out_oe) && oth_hist == 0);
endmodule
bind rtcal_top rtcal_top_properties chk (
    .core_clk(core_clk), .srst(srst), .cur_min(cur_min),
    .other_irq(other_irq), .chip_select(chip_select),
    .serial_clk(serial_clk), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .irq_out_n(irq_out_n),
    .irq_out_oe(irq_out_oe));

// ==== dv/rtcal_top_tb.sv ====
// Purpose: self-checking bench for the alarm and serial block
// Assumes: host model drives the link, bench drives the time inputs
// Notes:   read results checked by a watcher against a queue
`timescale 1ns/100ps
module rtcal_top_tb;
    typedef struct {logic [63:0] v; int nb;} rtcal_exp_t;
    logic       core_clk, srst, other_irq;
    logic [6:0] cur_min, cur_weekday;
    logic [5:0] cur_hour, cur_date;
    logic       chip_select, serial_clk, serial_in;
    logic       serial_out, serial_out_oe, irq_out_n, irq_out_oe;
    int         n_mismatch, n_tests, cyc;
    logic [31:0] rs = 32'h6A4D;
    rtcal_exp_t exp_q[$];
    logic [7:0] ta[4] = '{8'h2A, 8'h2A, 8'h15, 8'h15};
    logic [7:0] dsel[4] = '{8'h00, 8'h00, 8'h40, 8'h40};
    logic [6:0] wd[4] = '{7'h08, 7'h04, 7'h08, 7'h08};
    logic [5:0] dt[4] = '{6'h01, 6'h01, 6'h15, 6'h14};
    logic [7:0] fl[4] = '{8'h08, 8'h00, 8'h08, 8'h00};
    rtcal_top dut (.core_clk(core_clk), .srst(srst), .cur_min(cur_min),
        .cur_hour(cur_hour), .cur_weekday(cur_weekday),
        .cur_date(cur_date), .other_irq(other_irq),
        .chip_select(chip_select), .serial_clk(serial_clk),
        .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .irq_out_n(irq_out_n),
        .irq_out_oe(irq_out_oe));
    rtcal_host host (.chip_select(chip_select), .serial_clk(serial_clk),
        .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    ////////////////////////////////////////
    function automatic logic [7:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[7:0];
    endfunction
    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t read %h want %h", $time, g, e);
        end
    endtask
    task automatic cmp_bit(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t level %b want %b", $time, g, e);
        end
    endtask
    task automatic wrap_up();
        if (n_mismatch == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [63:0] d,
                      input int nb);
        exp_q.push_back('{64'h0, 0});
        host.xfer(({56'h0, a, rtcal_pkg::MODE_WRITE} << (8 * nb)) | d,
                  8 + 8 * nb);
        repeat (2) @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a, input int nb,
                      input logic [63:0] e);
        exp_q.push_back('{e, nb});
        host.xfer({56'h0, a, rtcal_pkg::MODE_READ} << (8 * nb), 8 + 8 * nb);
        repeat (2) @(posedge core_clk);
    endtask
    // minute step, then room for the event to reach the pin
    task automatic tick(input logic [6:0] m);
        @(posedge core_clk) cur_min <= m;
        repeat (6) @(posedge core_clk);
    endtask
    always @(host.got) begin
        rtcal_exp_t e;
        if (exp_q.size() != 0) begin
            e = exp_q.pop_front();
            for (int i = 0; i < e.nb; i++)
                cmp_byte(host.rv[8*i +: 8], e.v[8*i +: 8]);
        end
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 80000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    ////////////////////////////////////////
    initial begin
        logic [7:0] r0, r1, r2;
        srst <= 1'b1;
        other_irq <= 1'b0;
        cur_min <= 7'h10;
        cur_hour <= 6'h07;
        cur_weekday <= 7'h01;
        cur_date <= 6'h01;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(rtcal_pkg::ADDR_MIN_ALM, 3, 64'h0);
        r0 = rnd();
        r1 = rnd();
        r2 = rnd();
        wr(rtcal_pkg::ADDR_MIN_ALM, {r0, r1, r2}, 3);
        rd(rtcal_pkg::ADDR_MIN_ALM, 3, {r0, r1, r2});
        wr(rtcal_pkg::ADDR_CTRL, {8'h00, r0}, 2);
        rd(rtcal_pkg::ADDR_CTRL, 2, {8'h00, r0});
        for (int m = 0; m < 16; m++) begin
            if (m != 9 && m != 1) begin
                exp_q.push_back('{64'h0, 0});
                host.xfer({48'h0, 4'h0, 4'(m), r1}, 16);
                cmp_bit(host.saw_oe, 1'b0);
            end
        end
        rd(4'h0, 1, r0);
        exp_q.push_back('{64'h0, 0});
        host.xfer({52'h0, 4'h0, rtcal_pkg::MODE_WRITE, 4'hF}, 12);
        rd(4'h0, 1, r0);
        tick(7'h12);
        wr(rtcal_pkg::ADDR_EXT, {8'h00, 8'h00, 8'h08}, 3);
        wr(rtcal_pkg::ADDR_MIN_ALM, {8'h12, 8'h07, 8'h80}, 3);
        cmp_bit(irq_out_oe, 1'b0);
        tick(7'h13);
        cmp_bit(irq_out_oe, 1'b0);
        tick(7'h12);
        cmp_bit(irq_out_oe, 1'b1);
        rd(rtcal_pkg::ADDR_FLAG, 1, 8'h08);
        wr(rtcal_pkg::ADDR_FLAG, 8'h08, 1);
        cmp_bit(irq_out_oe, 1'b1);
        wr(rtcal_pkg::ADDR_FLAG, 8'h00, 1);
        cmp_bit(irq_out_oe, 1'b0);
        rd(rtcal_pkg::ADDR_FLAG, 1, 8'h00);
        wr(rtcal_pkg::ADDR_MIN_ALM, {8'h80, 8'h80, 8'h80}, 3);
        tick(7'h14);
        cmp_bit(irq_out_oe, 1'b1);
        wr(rtcal_pkg::ADDR_CTRL, 8'h00, 1);
        cmp_bit(irq_out_oe, 1'b0);
        wr(rtcal_pkg::ADDR_FLAG, 8'h00, 1);
        tick(7'h15);
        cmp_bit(irq_out_oe, 1'b0);
        rd(rtcal_pkg::ADDR_FLAG, 1, 8'h08);
        wr(rtcal_pkg::ADDR_EXT, {8'h00, 8'h00, 8'h01}, 3);
        tick(7'h16);
        rd(rtcal_pkg::ADDR_FLAG, 1, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(rtcal_pkg::ADDR_WD_ALM,
               {ta[i], rnd(), rnd(), dsel[i], 16'h0}, 6);
            // day and minute move on one edge, as the counters do
            @(posedge core_clk);
            cur_weekday <= wd[i];
            cur_date <= dt[i];
            cur_min <= 7'h20 + 7'(i);
            repeat (6) @(posedge core_clk);
            rd(rtcal_pkg::ADDR_FLAG, 1, fl[i]);
        end
        @(posedge core_clk) other_irq <= 1'b1;
        repeat (4) @(posedge core_clk);
        cmp_bit(irq_out_oe, 1'b1);
        other_irq <= 1'b0;
        repeat (4) @(posedge core_clk);
        cmp_bit(irq_out_oe, 1'b0);
        wrap_up();
    end
endmodule
